/* File: hw/bmc_cond_gen.sv */
// Purpose: Drives start, restart and stop on open-drain SCL and SDA.
// Assumes: SCL level arrives already synchronised; requests are single pulses.
// Notes: After a start the block keeps SCL and SDA low so the bus stays held.

`timescale 1ns/10ps
`default_nettype none

module bmc_cond_gen (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  bmc_cond_if.gen cif
);

  // ----------------
  // State
  // ----------------
  bmc_pkg::bmc_gen_state_t state;  // Current sequence step.
  bmc_pkg::bmc_gen_state_t next_state;
  logic [7:0] cnt;                 // Cycles left in the current step.
  logic [7:0] next_cnt;
  logic held;                      // Bus held by us after a start.
  logic next_held;
  logic scl_oe;                    // Registered pin enables.
  logic sda_oe;
  logic next_scl_oe;
  logic next_sda_oe;
  logic cnt_done;

  assign cnt_done = (cnt == 8'h01);

  // Sequencing; SCL is held high while SDA moves so others see the condition.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_held = held;
    next_scl_oe = held;
    next_sda_oe = held;
    case (state)
      bmc_pkg::GEN_IDLE: begin
        if (cif.start_req) begin
          next_state = bmc_pkg::GEN_S_REL;
          next_cnt = bmc_pkg::T_COND_CYC;
          next_sda_oe = 1'b0; // [R20]
        end else if (cif.stop_req) begin
          next_state = bmc_pkg::GEN_P_SDA;
          next_cnt = bmc_pkg::T_COND_CYC;
          next_sda_oe = 1'b1;
          next_scl_oe = 1'b1;
        end
      end
      bmc_pkg::GEN_S_REL: begin
        // Release both lines; wait for SCL really high, since a slave may stretch it.
        next_sda_oe = 1'b0;
        next_scl_oe = 1'b0;
        if (cif.scl_hi) begin
          next_cnt = cnt - 8'h01;
          if (cnt_done) begin
            next_state = bmc_pkg::GEN_S_SDA;
            next_cnt = bmc_pkg::T_COND_CYC;
            next_sda_oe = 1'b1; // [R20]
          end
        end
      end
      bmc_pkg::GEN_S_SDA: begin
        // SDA low with SCL high forms the start; hold it before taking SCL.
        next_sda_oe = 1'b1;
        next_scl_oe = 1'b0;
        next_cnt = cnt - 8'h01;
        if (cnt_done) begin
          next_state = bmc_pkg::GEN_S_SCL;
          next_scl_oe = 1'b1;
        end
      end
      bmc_pkg::GEN_S_SCL: begin
        next_sda_oe = 1'b1;
        next_scl_oe = 1'b1;
        next_held = 1'b1;
        next_state = bmc_pkg::GEN_IDLE;
      end
      bmc_pkg::GEN_P_SDA: begin
        // SDA low while SCL is still low, so no false start appears.
        next_sda_oe = 1'b1;
        next_scl_oe = 1'b1;
        next_cnt = cnt - 8'h01;
        if (cnt_done) begin
          next_state = bmc_pkg::GEN_P_REL;
          next_cnt = bmc_pkg::T_COND_CYC;
          next_scl_oe = 1'b0;
        end
      end
      bmc_pkg::GEN_P_REL: begin
        next_sda_oe = 1'b1;
        next_scl_oe = 1'b0;
        if (cif.scl_hi) begin
          next_cnt = cnt - 8'h01;
          if (cnt_done) begin
            next_state = bmc_pkg::GEN_P_END;
            next_cnt = bmc_pkg::T_COND_CYC;
            next_sda_oe = 1'b0; // [R20]
          end
        end
      end
      bmc_pkg::GEN_P_END: begin
        // Bus free time after the stop before a new request is taken.
        next_sda_oe = 1'b0;
        next_scl_oe = 1'b0;
        next_held = 1'b0;
        next_cnt = cnt - 8'h01;
        if (cnt_done) begin
          next_state = bmc_pkg::GEN_IDLE;
        end
      end
      default: begin
        next_state = bmc_pkg::GEN_IDLE;
        next_held = 1'b0;
        next_sda_oe = 1'b0;
        next_scl_oe = 1'b0;
      end
    endcase
  end

  // Register the sequence state and the pin enables.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= bmc_pkg::GEN_IDLE;
      cnt <= 8'h00;
      held <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      held <= next_held;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  assign cif.gen_busy = (state != bmc_pkg::GEN_IDLE);
  assign cif.scl_oe = scl_oe;
  assign cif.sda_oe = sda_oe;

endmodule // bmc_cond_gen

`default_nettype wire

/* File: hw/bmc_cond_if.sv */
// Purpose: Carrier between the control logic and the condition generator.
// Assumes: Both ends run on the same reference clock.
// Notes: Requests are one-cycle pulses; enables are levels.

`timescale 1ns/10ps
`default_nettype none

interface bmc_cond_if;
  logic start_req;  // Pulse: issue a start or repeated start.
  logic stop_req;   // Pulse: issue a stop.
  logic scl_hi;     // Synchronised SCL level.
  logic gen_busy;   // High while a sequence is running.
  logic scl_oe;     // High while SCL is pulled low.
  logic sda_oe;     // High while SDA is pulled low.

  modport ctl (output start_req, output stop_req, output scl_hi,
               input gen_busy, input scl_oe, input sda_oe);
  modport gen (input start_req, input stop_req, input scl_hi,
               output gen_busy, output scl_oe, output sda_oe);
endinterface : bmc_cond_if

`default_nettype wire

/* File: hw/bmc_pkg.sv */
// Purpose: Constants and types of the mode control block.
// Assumes: 25 MHz reference clock and an 8-bit register port with a 2-bit address.
// Notes: All offsets, fields, timings and the reset values of the stored control bits live here.

package bmc_pkg;

  // ----------------
  // Register map
  // ----------------
  localparam logic [1:0] ADDR_MODE_CTRL = 2'h0;  // Bus mode control register.
  localparam logic [1:0] ADDR_STATUS = 2'h1;     // Bus status register.

  // Field positions in the bus mode control register.
  localparam int BIT_MASTER_SELECT = 5;
  localparam int BIT_TRANSMIT_SELECT = 4;
  localparam int BIT_ACK_CHECK_ENABLE = 3;
  localparam int BIT_LINE_OCCUPIED = 2;
  localparam int BIT_START_STOP_INHIBIT = 0;

  // Field position in the bus status register.
  localparam int BIT_RECEIVED_ACK = 0;

  // Reset values of the stored control bits.
  localparam logic RST_MASTER_SELECT = 1'b0;
  localparam logic RST_TRANSMIT_SELECT = 1'b0;
  localparam logic RST_ACK_CHECK_ENABLE = 1'b0;
  localparam logic RST_LINE_OCCUPIED = 1'b0;
  localparam logic START_STOP_INHIBIT_READ = 1'b1;  // Constant read value.

  // ----------------
  // Timing
  // ----------------
  localparam int CLK_MHZ = 25;       // Reference clock rate in MHz.
  localparam int T_COND_NS = 5000;   // Least setup and hold around a condition, ns.
  // Least time, so round up to whole reference clock cycles.
  localparam int T_COND_CYC_INT = (T_COND_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] T_COND_CYC = 8'(T_COND_CYC_INT);

  // ----------------
  // Types
  // ----------------
  // Operating mode as decoded from master select and transmit select.
  typedef enum logic [1:0] {
    MODE_SLAVE_RX = 2'b00,
    MODE_SLAVE_TX = 2'b01,
    MODE_MASTER_RX = 2'b10,
    MODE_MASTER_TX = 2'b11
  } bmc_mode_t;

  // Condition generator sequence states.
  typedef enum logic [2:0] {
    GEN_IDLE = 3'h0,
    GEN_S_REL = 3'h1,
    GEN_S_SDA = 3'h2,
    GEN_S_SCL = 3'h3,
    GEN_P_SDA = 3'h4,
    GEN_P_REL = 3'h5,
    GEN_P_END = 3'h6
  } bmc_gen_state_t;

endpackage : bmc_pkg

/* File: hw/bmc_top.sv */
// Purpose: Mode bits, ack check and start/stop control.
// Assumes: Engine inputs on i_ref_clk; SCL and SDA asynchronous.
// Notes: Open-drain pins pull low while the enable is high.

`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] Master bit cleared by write 0 or lost arbitration.
// [R2] After loss, set master only after reading 0.
// [R3] Auto-set transmit clears only after reading 1.
// [R4] After loss, set transmit only after reading 0.
// [R5] Slave address match with R/W 1 sets transmit.
// [R6] Lost arbitration as master clears transmit bit.
// [R7] Ack check off: ignore ack, status reads 0.
// [R8] Ack check on: received 1 halts transfer.
// [R9] Master write busy 0, inhibit 0 issues stop.
// [R10] Master write busy 1, inhibit 0 issues start.
// [R11] Slave mode ignores writes to busy bit.
// [R12] SDA fall with SCL high sets busy.
// [R13] SDA rise with SCL high clears busy.
// [R14] Software sets master transmit before start request.
// [R15] Inhibit bit reads 1, written 0 not stored.
// [R16] Writes never change the busy bit value.
// [R17] Busy bit readable to show bus occupancy.
// [R18] Mode decode: 00 SR, 01 ST, 10 MR, 11 MT.
// [R19] Transmit change during transfer waits until done.
// [R20] Conditions driven with SCL high while SDA moves.
module bmc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_arb_lost,
  input wire logic i_addr_match_rw,
  input wire logic i_rw_bit,
  input wire logic i_ack_valid,
  input wire logic i_ack_bit,
  input wire logic i_xfer_busy,
  output logic [1:0] o_mode,
  output logic o_halt
);

  // ----------------
  // Helpers
  // ----------------
  // Decode an access strobe aimed at one register.
  function automatic logic hit(input logic strobe, input logic [1:0] addr, input logic [1:0] target);
    hit = strobe && (addr == target);
  endfunction

  // ----------------
  // Stored state
  // ----------------
  logic master_select;       // Master mode when high.
  logic transmit_select;     // Transmit mode when high.
  logic ack_check_enable;    // Received acknowledge is checked when high.
  logic line_occupied_flag;  // Bus seen busy between start and stop.
  logic received_ack_flag;   // Last received acknowledge, when checked.
  logic mst_loss_lock;       // Master set refused until master read as 0.
  logic trs_loss_lock;       // Transmit set refused until transmit read as 0.
  logic trs_match_lock;      // Transmit clear refused until transmit read as 1.
  logic trs_pend;            // A deferred transmit change waits.
  logic trs_pend_val;        // The value that the deferred change brings.

  // Pin synchronisers; stage one feeds stage two only.
  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;

  logic ctrl_wr;       // Write to the mode control register.
  logic ctrl_rd;       // Read of the mode control register.
  logic arb_loss;      // Arbitration loss while operating as master.
  logic cond_start;    // Start seen on the bus.
  logic cond_stop;     // Stop seen on the bus.
  logic trs_wr_ok;     // Software transmit write passes its locks.
  logic [7:0] rd_value;

  bmc_cond_if cif();

  assign ctrl_wr = hit(i_wr, i_addr, bmc_pkg::ADDR_MODE_CTRL);
  assign ctrl_rd = hit(i_rd, i_addr, bmc_pkg::ADDR_MODE_CTRL);
  assign arb_loss = i_arb_lost && master_select;

  // ----------------
  // Bus line monitor
  // ----------------
  // Two flops per pin, then a third stage used only for edge detection.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // SCL must be high on both samples so a data change near a clock edge is not taken.
  assign cond_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2; // [R12]
  assign cond_stop = scl_s2 && scl_s3 && !sda_s3 && sda_s2; // [R13]

  // Busy follows the bus alone; software writes never reach it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_occupied_flag <= bmc_pkg::RST_LINE_OCCUPIED;
    end else if (cond_start) begin
      line_occupied_flag <= 1'b1; // [R12] [R16]
    end else if (cond_stop) begin
      line_occupied_flag <= 1'b0; // [R13] [R16]
    end
  end

  // ----------------
  // Master select
  // ----------------
  // Hardware loss wins over a software write in the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      master_select <= bmc_pkg::RST_MASTER_SELECT;
    end else if (arb_loss) begin
      master_select <= 1'b0; // [R1]
    end else if (ctrl_wr) begin
      if (!i_wdata[bmc_pkg::BIT_MASTER_SELECT]) begin
        master_select <= 1'b0; // [R1]
      end else if (!mst_loss_lock) begin
        master_select <= 1'b1; // [R2]
      end
    end
  end

  // Loss lock: hardware sets, a read of 0 clears; set wins.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mst_loss_lock <= 1'b0;
    end else if (arb_loss) begin
      mst_loss_lock <= 1'b1; // [R2]
    end else if (ctrl_rd && !master_select) begin
      mst_loss_lock <= 1'b0; // [R2]
    end
  end

  // ----------------
  // Transmit select
  // ----------------
  // A write of 1 needs the loss lock open; a write of 0 needs the match lock open.
  assign trs_wr_ok = i_wdata[bmc_pkg::BIT_TRANSMIT_SELECT] ? !trs_loss_lock : !trs_match_lock; // [R3] [R4]

  // Hardware events first, then a deferred change once the transfer ends.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      transmit_select <= bmc_pkg::RST_TRANSMIT_SELECT;
      trs_pend <= 1'b0;
      trs_pend_val <= 1'b0;
    end else if (arb_loss) begin
      transmit_select <= 1'b0; // [R6]
      trs_pend <= 1'b0;
    end else if (i_addr_match_rw && !master_select) begin
      transmit_select <= i_rw_bit; // [R5]
      trs_pend <= 1'b0;
    end else if (ctrl_wr && trs_wr_ok) begin
      if (i_xfer_busy) begin
        trs_pend <= 1'b1; // [R19]
        trs_pend_val <= i_wdata[bmc_pkg::BIT_TRANSMIT_SELECT];
      end else begin
        transmit_select <= i_wdata[bmc_pkg::BIT_TRANSMIT_SELECT]; // [R3] [R4] [R6]
        trs_pend <= 1'b0;
      end
    end else if (trs_pend && !i_xfer_busy) begin
      transmit_select <= trs_pend_val; // [R19]
      trs_pend <= 1'b0;
    end
  end

  // Loss lock: needs a read of 0 before a write of 1 is taken again.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trs_loss_lock <= 1'b0;
    end else if (arb_loss) begin
      trs_loss_lock <= 1'b1; // [R4]
    end else if (ctrl_rd && !transmit_select) begin
      trs_loss_lock <= 1'b0; // [R4]
    end
  end

  // Match lock: an automatic set needs a read of 1 before a write of 0 is taken.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trs_match_lock <= 1'b0;
    end else if (i_addr_match_rw && !master_select && i_rw_bit && !arb_loss) begin
      trs_match_lock <= 1'b1; // [R3]
    end else if (ctrl_rd && transmit_select) begin
      trs_match_lock <= 1'b0; // [R3]
    end
  end

  // ----------------
  // Acknowledge check
  // ----------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_check_enable <= bmc_pkg::RST_ACK_CHECK_ENABLE;
    end else if (ctrl_wr) begin
      ack_check_enable <= i_wdata[bmc_pkg::BIT_ACK_CHECK_ENABLE];
    end
  end

  // With checking off the flag is held at 0, so status always reads 0.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      received_ack_flag <= 1'b0;
    end else if (!ack_check_enable) begin
      received_ack_flag <= 1'b0; // [R7]
    end else if (i_ack_valid) begin
      received_ack_flag <= i_ack_bit; // [R8]
    end
  end

  // Halt is a level; it stays until a 0 acknowledge or check off.
  assign o_halt = ack_check_enable && received_ack_flag; // [R7] [R8]

  // ----------------
  // Start and stop requests
  // ----------------
  // Only a master write with inhibit 0 commands; slave writes do nothing.
  // Software must have chosen master transmit before asking for a start.
  always_comb begin
    cif.start_req = 1'b0;
    cif.stop_req = 1'b0;
    if (ctrl_wr && master_select && !i_wdata[bmc_pkg::BIT_START_STOP_INHIBIT] && !cif.gen_busy) begin // [R11] [R14]
      if (i_wdata[bmc_pkg::BIT_LINE_OCCUPIED]) begin
        cif.start_req = 1'b1; // [R10]
      end else begin
        cif.stop_req = 1'b1; // [R9]
      end
    end
  end

  assign cif.scl_hi = scl_s2;

  bmc_cond_gen u_cond_gen (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .cif(cif)
  );

  // Open drain: the data value is always low, the enable decides.
  assign o_scl = 1'b0; // [R20]
  assign o_sda = 1'b0; // [R20]
  assign o_scl_oe = cif.scl_oe;
  assign o_sda_oe = cif.sda_oe;

  // ----------------
  // Read port
  // ----------------
  // Read value assembly; unused bits read as zero.
  always_comb begin
    rd_value = 8'h00;
    if (i_addr == bmc_pkg::ADDR_MODE_CTRL) begin
      rd_value[bmc_pkg::BIT_MASTER_SELECT] = master_select;
      rd_value[bmc_pkg::BIT_TRANSMIT_SELECT] = transmit_select;
      rd_value[bmc_pkg::BIT_ACK_CHECK_ENABLE] = ack_check_enable;
      rd_value[bmc_pkg::BIT_LINE_OCCUPIED] = line_occupied_flag; // [R17]
      rd_value[bmc_pkg::BIT_START_STOP_INHIBIT] = bmc_pkg::START_STOP_INHIBIT_READ; // [R15]
    end else if (i_addr == bmc_pkg::ADDR_STATUS) begin
      rd_value[bmc_pkg::BIT_RECEIVED_ACK] = received_ack_flag; // [R7]
    end
  end

  // Data stand only in the cycle after the strobe, else zero.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rd_value;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Mode output; the two bits decode directly to the four modes.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode <= bmc_pkg::MODE_SLAVE_RX;
    end else begin
      o_mode <= {master_select, transmit_select}; // [R18]
    end
  end

endmodule // bmc_top

`default_nettype wire

/* File: tb/bmc_line_model.sv */
// Purpose: Far side of the two-wire bus: pull-ups and one other master.
// Assumes: Open-drain lines with pull-ups; the other master clocks at 320 ns.
// Notes: SCL stands high outside frames, as a released line does.
`timescale 1ns/10ps
`default_nettype none
module bmc_line_model (
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  output wire logic o_scl,
  output wire logic o_sda
);
  // ----------------
  // Wired-AND lines
  // ----------------
  logic far_scl_low = 1'b0;  // The other master pulls SCL.
  logic far_sda_low = 1'b0;  // The other master pulls SDA.
  // A line nobody pulls floats up to the pull-up level, never to the last value.
  assign o_scl = !(i_scl_oe || far_scl_low);
  assign o_sda = !(i_sda_oe || far_sda_low);
  // Start with SCL high, then clock three zero bits and park with SCL high.
  task automatic far_start();
    far_sda_low = 1'b1;
    #160;
    repeat (3) begin
      far_scl_low = 1'b1;
      #160;
      far_scl_low = 1'b0;
      #160;
    end
  endtask
  // Releasing SDA while SCL is high makes a stop.
  task automatic far_stop();
    far_sda_low = 1'b0;
  endtask
endmodule // bmc_line_model
`default_nettype wire

/* File: tb/bmc_top_bench.sv */
// Purpose: Self-checking bench of the bus mode and start/stop control block.
// Assumes: 25 MHz clock; bus lines come from the line model with pull-ups.
// Notes: Table rows cover the mode decode; the awkward cases follow by hand.
`timescale 1ns/10ps
`default_nettype none
module bmc_top_bench;
  // ----------------
  // Signals, table and instances
  // ----------------
  logic i_ref_clk, i_rst_n, i_wr, i_rd, i_arb_lost, i_addr_match_rw, i_rw_bit, o_scl, o_sda;
  logic i_ack_valid, i_ack_bit, i_xfer_busy, o_halt, o_scl_oe, o_sda_oe;
  logic [1:0] i_addr, o_mode;
  logic [7:0] i_wdata, o_rdata;
  wire logic scl_w, sda_w;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  typedef struct {logic [7:0] wd; logic [7:0] ex; logic [1:0] md;} bmc_row_t;
  // Write, read-back, mode; bit 0 at 1 sends no command.
  bmc_row_t rows [6] = '{'{8'h01, 8'h01, 2'h0}, '{8'h11, 8'h11, 2'h1}, '{8'h21, 8'h21, 2'h2},
    '{8'h31, 8'h31, 2'h3}, '{8'h3d, 8'h39, 2'h3}, '{8'hc1, 8'h01, 2'h0}};
  bmc_top i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
    .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_arb_lost(i_arb_lost),
    .i_addr_match_rw(i_addr_match_rw), .i_rw_bit(i_rw_bit), .i_ack_valid(i_ack_valid),
    .i_ack_bit(i_ack_bit), .i_xfer_busy(i_xfer_busy), .o_mode(o_mode), .o_halt(o_halt));
  bmc_line_model i_line (.i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe), .o_scl(scl_w), .o_sda(sda_w));
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  // A hang ends the run with a mismatch rather than running forever.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      $display("BAD %s expected %h seen %h", nm, ex, got);
      bad_count++;
    end
  endtask
  // Step past the edge so registered outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [1:0] a, input logic [7:0] ex, input string nm);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    tick(1);
    i_rd <= 1'b0;
    chk(nm, ex, o_rdata);
  endtask
  // One-cycle event: 0 arbitration loss, 1 address match, 2 received ack.
  task automatic ev(input logic [1:0] k, input logic b);
    @(posedge i_ref_clk);
    i_arb_lost <= (k == 2'h0);
    i_addr_match_rw <= (k == 2'h1);
    i_ack_valid <= (k == 2'h2);
    i_rw_bit <= b;
    i_ack_bit <= b;
    @(posedge i_ref_clk);
    {i_arb_lost, i_addr_match_rw, i_ack_valid} <= 3'h0;
  endtask
  task automatic wait_oe(input logic sda, input logic v);
    for (int n = 0; (sda ? o_sda_oe : o_scl_oe) !== v && n < 400; n++) begin
      tick(1);
    end
    chk("line enable", {7'h0, v}, {7'h0, sda ? o_sda_oe : o_scl_oe});
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    i_rst_n = 1'b0;
    {i_wr, i_rd, i_arb_lost, i_addr_match_rw, i_rw_bit, i_ack_valid, i_ack_bit, i_xfer_busy} = 8'h00;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(2'h0, rows[i].wd);
      rd(2'h0, rows[i].ex, "control");
      chk("mode", {6'h0, rows[i].md}, {6'h0, o_mode});
    end
    wr(2'h2, 8'h3f);
    rd(2'h3, 8'h00, "unmapped");
    rd(2'h0, 8'h01, "control");
    ev(2'h2, 1'b1);
    rd(2'h1, 8'h00, "ack ignored");
    wr(2'h0, 8'h09);
    ev(2'h2, 1'b1);
    rd(2'h1, 8'h01, "ack seen");
    chk("halt", 8'h01, {7'h0, o_halt});
    // Arbitration loss clears both bits, and a set needs a read of 0 first.
    wr(2'h0, 8'h31);
    ev(2'h0, 1'b0);
    tick(1);
    chk("lost mode", 8'h00, {6'h0, o_mode});
    wr(2'h0, 8'h31);
    rd(2'h0, 8'h01, "locked");
    wr(2'h0, 8'h31);
    rd(2'h0, 8'h31, "unlocked");
    wr(2'h0, 8'h01);
    ev(2'h1, 1'b1);
    wr(2'h0, 8'h01);
    tick(1);
    chk("match mode", 8'h01, {6'h0, o_mode});
    rd(2'h0, 8'h11, "match");
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h01, "cleared");
    @(posedge i_ref_clk);
    i_xfer_busy <= 1'b1;
    wr(2'h0, 8'h11);
    rd(2'h0, 8'h01, "deferred");
    @(posedge i_ref_clk);
    i_xfer_busy <= 1'b0;
    rd(2'h0, 8'h11, "applied");
    wr(2'h0, 8'h04);
    tick(10);
    chk("slave write", 8'h00, {6'h0, o_scl_oe, o_sda_oe});
    chk("pin data", 8'h00, {6'h0, o_scl, o_sda});
    rd(2'h0, 8'h01, "slave busy");
    // Start, repeated start and stop as master transmitter.
    wr(2'h0, 8'h31);
    wr(2'h0, 8'h34);
    wait_oe(1'b1, 1'b1);
    chk("SCL high", 8'h01, {7'h0, scl_w});
    wait_oe(1'b0, 1'b1);
    rd(2'h0, 8'h35, "held");
    tick(10);
    wr(2'h0, 8'h34);
    wait_oe(1'b1, 1'b0);
    wait_oe(1'b1, 1'b1);
    wait_oe(1'b0, 1'b1);
    tick(10);
    wr(2'h0, 8'h30);
    wait_oe(1'b0, 1'b0);
    wait_oe(1'b1, 1'b0);
    tick(5);
    rd(2'h0, 8'h31, "freed");
    // Another master takes the bus while this end is a slave.
    wr(2'h0, 8'h01);
    i_line.far_start();
    tick(5);
    rd(2'h0, 8'h05, "far busy");
    wr(2'h0, 8'h01);
    rd(2'h0, 8'h05, "busy kept");
    i_line.far_stop();
    tick(5);
    rd(2'h0, 8'h01, "far free");
    // A reset in mid-run returns every bit to its initial value.
    wr(2'h0, 8'h39);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(2'h0, 8'h01, "after reset");
    results();
  end
endmodule // bmc_top_bench
bind bmc_top bmc_top_props i_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_scl_oe(o_scl_oe),
  .o_sda_oe(o_sda_oe), .i_arb_lost(i_arb_lost), .i_addr_match_rw(i_addr_match_rw),
  .i_rw_bit(i_rw_bit), .i_ack_valid(i_ack_valid), .i_ack_bit(i_ack_bit), .o_mode(o_mode),
  .o_halt(o_halt));
`default_nettype wire

/* File: tb/bmc_top_props.sv */
// Purpose: Port checker of the bus mode and start/stop control block.
// Assumes: One clock domain; bound to bmc_top.
// Notes: Mirrors only the ack check bit, taken from register writes.
`timescale 1ns/10ps
`default_nettype none
module bmc_top_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic i_arb_lost,
  input wire logic i_addr_match_rw,
  input wire logic i_rw_bit,
  input wire logic i_ack_valid,
  input wire logic i_ack_bit,
  input wire logic [1:0] o_mode,
  input wire logic o_halt
);
  // ----------------
  // Helpers and properties
  // ----------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic ack_en;  // Mirror of the ack check bit.
  logic cmd;     // A mode control write with the inhibit bit at 0.
  assign cmd = i_wr && i_addr == 2'h0 && !i_wdata[0];
  // Follow the ack check bit so no status read is needed to judge the halt.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_en <= 1'b0;
    end else if (i_wr && i_addr == 2'h0) begin
      ack_en <= i_wdata[3];
    end
  end
  // SDA is pulled only after a long wait with SCL released.
  sequence s_start;
    !o_scl_oe throughout ##[120:140] o_sda_oe;
  endsequence
  // SDA stays pulled until well after SCL has been released.
  sequence s_stop;
    (o_sda_oe throughout ##[120:130] !o_scl_oe) ##[120:140] !o_sda_oe;
  endsequence
  a_arb_clear: assert property (i_arb_lost && o_mode[1] |-> ##2 o_mode == 2'h0)
    else $error("mode kept after arbitration loss");
  a_match_tx: assert property (i_addr_match_rw && i_rw_bit && !o_mode[1] |-> ##2 o_mode[0])
    else $error("transmit not set on address match");
  a_ack_ignored: assert property (!ack_en |-> !o_halt)
    else $error("halt with ack check off");
  a_ack_halts: assert property (i_ack_valid && i_ack_bit && ack_en |=> o_halt)
    else $error("no halt on received ack of 1");
  a_start_cond: assert property (cmd && i_wdata[2] && o_mode[1] && !o_scl_oe && !o_sda_oe |=> s_start)
    else $error("bad start sequence");
  a_stop_cond: assert property (cmd && !i_wdata[2] && o_mode[1] && o_scl_oe && o_sda_oe |=> s_stop)
    else $error("bad stop sequence");
  a_slave_quiet: assert property (cmd && !o_mode[1] && !o_scl_oe && !o_sda_oe |=> (!o_scl_oe && !o_sda_oe) [*8])
    else $error("line driven after slave write");
  a_sda_moves: assert property ($changed(o_sda_oe) |-> $stable(o_scl_oe))
    else $error("SDA and SCL moved together");
  a_inhibit_one: assert property (i_rd && i_addr == 2'h0 |=> o_rdata[0] && o_rdata[7:6] == 2'h0)
    else $error("inhibit bit not read as 1");
endmodule // bmc_top_props
`default_nettype wire
